// *** common/odtb_defs.svh ***
/*
 offsets, field positions, reset values and timing counts of the on-delay timer bank.
 assumes a 32-bit apb slave with byte addresses and a 50 mhz pclk.
*/
`ifndef ODTB_DEFS_SVH
`define ODTB_DEFS_SVH

// ==========================================================
// register byte offsets
`define ODTB_OFS_SLOT 12'h000
`define ODTB_OFS_SETVAL 12'h004
`define ODTB_OFS_POINTER 12'h008
`define ODTB_OFS_EXEC 12'h00c
`define ODTB_OFS_MODE 12'h010
`define ODTB_OFS_FLAG 12'h014
`define ODTB_OFS_PV 12'h018
`define ODTB_OFS_ERROR 12'h01c
`define ODTB_OFS_IRQ_STATUS 12'h020
`define ODTB_OFS_IRQ_CLEAR 12'h024
`define ODTB_OFS_IRQ_ENABLE 12'h028

// ==========================================================
// field positions
`define ODTB_MODE_ALL_RESET_BIT 8
`define ODTB_FLAG_DONE_BIT 0
`define ODTB_FLAG_PULSE_BIT 1
`define ODTB_IRQ_DONE_BIT 0
`define ODTB_IRQ_ERROR_BIT 1
`define ODTB_IRQ_REFUSED_BIT 2

// ==========================================================
// reset values and limits
`define ODTB_SLOT_RESET 9'h000
`define ODTB_WORD_RESET 16'h0000
`define ODTB_IRQ_RESET 3'h0
`define ODTB_DM_LAST 16'h1999
`define ODTB_SLOT_COUNT 512

// ==========================================================
// timing
`define ODTB_CLK_NS 20
`define ODTB_TICK_MS 100
`define ODTB_HALF_PULSE_MS 500
`define ODTB_TICK_CYCLES ((`ODTB_TICK_MS * 1000000) / `ODTB_CLK_NS)
`define ODTB_HALF_PULSE_CYCLES ((`ODTB_HALF_PULSE_MS * 1000000) / `ODTB_CLK_NS)

`endif

// *** common/odtb_pkg.sv ***
/*
 types of the on-delay timer bank: controller mode and the decoded execute command.
 assumes nothing of its surroundings.
*/
package odtb_pkg;

   // ==========================================================
   // controller operating mode
   typedef enum logic [1:0] {
      ODTB_MODE_PROGRAM,
      ODTB_MODE_MONITOR,
      ODTB_MODE_RUN,
      ODTB_MODE_SPARE
   } odtb_mode_t;

   // ==========================================================
   // execute command word, low bits of the exec register
   typedef struct packed {
      logic step_reset;
      logic jump_zero;
      logic skipped;
      logic interlock_off;
      logic sv_from_input;
      logic indirect;
      logic condition;
   } odtb_exec_t;

endpackage

// *** verilog/odtb_timer_bank.sv ***
/*
 bank of 512 decrementing bcd on-delay timers behind an apb slave, with sticky
 interrupt status, 0.1 s timebase and a one-second clock pulse bit.
 assumes a scan engine that issues one execute write per timer instruction per scan,
 and an input-unit word on ext_set_value from outside the pclk domain.
*/
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "odtb_defs.svh"

// Contract
// - slots 000 to 511, each defined once, readable as operand any number of times
// - bit read of slot returns completion flag, off until set value elapses
// - word read of slot returns the present value
// - condition on starts timing; condition off reloads set value, clears flag
// - active timer decrements present value in 0.1 s steps
// - at zero with condition on, flag turns on until condition goes off
// - interlock off resets timers; power interruption resets all timers
// - non-bcd set value sets error flag, execution continues
// - indirect pointer not bcd or past data memory boundary sets error flag
// - set value zero completes on off-to-on transition of the input
// - elapsed time may be short by one tick; set value one may finish at once
// - zero set value in skipped jump 00 section still turns flag on
// - zero set value in held-reset step still turns flag on
// - set value from constant or word; input-unit word only in run or monitor
// - one-second clock pulse bit is on 0.5 s then off 0.5 s
module odtb_timer_bank #(
   parameter int TICK_CYCLES = `ODTB_TICK_CYCLES,
   parameter int HALF_PULSE_CYCLES = `ODTB_HALF_PULSE_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // input-unit word wired to external switches
   input wire logic [15:0] ext_set_value,
   // status outputs
   output logic clock_pulse_1s,
   output logic instruction_error_flag,
   output logic irq
);
   import odtb_pkg::*;

   // ==========================================================
   // decode helpers
   function automatic logic is_bcd(input logic [15:0] w);
      is_bcd = (w[15:12] <= 4'h9) && (w[11:8] <= 4'h9) && (w[7:4] <= 4'h9)
         && (w[3:0] <= 4'h9);
   endfunction

   // one bcd step down, holding at zero
   function automatic logic [15:0] bcd_dec(input logic [15:0] w);
      logic [15:0] r;
      logic borrow;
      r = w;
      borrow = 1'b1;
      if (w == 16'h0000) begin
         bcd_dec = w;
      end else begin
         for (int d = 0; d < 4; d++) begin
            if (borrow) begin
               if (w[d*4 +: 4] == 4'h0) begin
                  r[d*4 +: 4] = 4'h9;
               end else begin
                  r[d*4 +: 4] = w[d*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
         bcd_dec = r;
      end
   endfunction

   function automatic logic is_write(input logic [11:0] a, input logic [11:0] ofs,
      input logic s, input logic e, input logic w, input logic rdy);
      is_write = s && e && w && rdy && (a == ofs);
   endfunction

   // ==========================================================
   // state
   logic [8:0] slot;
   logic [15:0] set_value;
   logic [15:0] pointer;
   odtb_mode_t mode;
   logic [2:0] irq_status;
   logic [2:0] irq_enable;
   logic [15:0] present_value [0:`ODTB_SLOT_COUNT-1];
   logic [`ODTB_SLOT_COUNT-1:0] done_flag;
   logic [`ODTB_SLOT_COUNT-1:0] cond_prev;
   logic [`ODTB_SLOT_COUNT-1:0] tick_pend;
   logic [`ODTB_SLOT_COUNT-1:0] tick_clear;
   logic [31:0] tick_count;
   logic [31:0] pulse_count;
   logic tick;
   logic [15:0] ext_s1;
   logic [15:0] ext_s2;
   logic [15:0] ext_s3;
   logic [15:0] ext_stable;

   // ==========================================================
   // bus strobes
   logic access;
   logic wr_exec;
   logic wr_mode;
   logic all_reset;
   odtb_exec_t cmd;

   assign access = psel && penable && pready;
   assign wr_exec = is_write(paddr, `ODTB_OFS_EXEC, psel, penable, pwrite, pready);
   assign wr_mode = is_write(paddr, `ODTB_OFS_MODE, psel, penable, pwrite, pready);
   assign all_reset = wr_mode && pwdata[`ODTB_MODE_ALL_RESET_BIT];
   assign cmd = odtb_exec_t'(pwdata[6:0]);

   // ==========================================================
   // input-unit synchroniser, value taken once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1 <= `ODTB_WORD_RESET;
         ext_s2 <= `ODTB_WORD_RESET;
         ext_s3 <= `ODTB_WORD_RESET;
         ext_stable <= `ODTB_WORD_RESET;
      end else begin
         ext_s1 <= ext_set_value;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         if (ext_s2 == ext_s3) begin
            ext_stable <= ext_s3;
         end
      end
   end

   // ==========================================================
   // 0.1 s timebase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_count <= 32'h0;
         tick <= 1'b0;
      end else if (tick_count >= 32'(TICK_CYCLES - 1)) begin
         tick_count <= 32'h0;
         tick <= 1'b1;
      end else begin
         tick_count <= tick_count + 32'h1;
         tick <= 1'b0;
      end
   end

   // one-second clock pulse, half period each level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_count <= 32'h0;
         clock_pulse_1s <= 1'b0;
      end else if (pulse_count >= 32'(HALF_PULSE_CYCLES - 1)) begin
         pulse_count <= 32'h0;
         clock_pulse_1s <= !clock_pulse_1s;
      end else begin
         pulse_count <= pulse_count + 32'h1;
      end
   end

   // ==========================================================
   // per-slot pending tick, a new tick wins over its consumption
   generate
      for (genvar g = 0; g < `ODTB_SLOT_COUNT; g++) begin : g_pend
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tick_pend[g] <= 1'b0;
            end else if (tick) begin
               tick_pend[g] <= 1'b1;
            end else if (tick_clear[g] || all_reset) begin
               tick_pend[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // timer instruction execution for the addressed slot
   logic [15:0] cur_pv;
   logic cur_flag;
   logic cur_prev;
   logic [15:0] sv_eff;
   logic [15:0] next_pv;
   logic next_flag;
   logic next_prev;
   logic exec_go;
   logic exec_err;
   logic exec_refused;
   logic done_event;

   assign cur_pv = present_value[slot];
   assign cur_flag = done_flag[slot];
   assign cur_prev = cond_prev[slot];

   always_comb begin
      sv_eff = set_value;
      next_pv = cur_pv;
      next_flag = cur_flag;
      next_prev = cur_prev;
      exec_go = 1'b0;
      exec_err = 1'b0;
      exec_refused = 1'b0;
      tick_clear = '0;
      if (wr_exec) begin
         exec_go = 1'b1;
         if (cmd.sv_from_input) begin
            sv_eff = ext_stable;
            if (mode != ODTB_MODE_RUN && mode != ODTB_MODE_MONITOR) begin
               exec_go = 1'b0;
               exec_refused = 1'b1;
            end
         end
         if (cmd.indirect && (!is_bcd(pointer) || pointer > `ODTB_DM_LAST)) begin
            exec_go = 1'b0;
            exec_err = 1'b1;
         end
         if (exec_go && !is_bcd(sv_eff)) begin
            exec_err = 1'b1;
         end
      end
      if (exec_go) begin
         if (cmd.step_reset) begin
            next_pv = sv_eff;
            next_flag = (sv_eff == 16'h0000);
            next_prev = 1'b0;
         end else if (cmd.interlock_off || (!cmd.skipped && !cmd.condition)) begin
            next_pv = sv_eff;
            next_flag = 1'b0;
            next_prev = 1'b0;
         end else if (cmd.skipped) begin
            if (cmd.jump_zero && sv_eff == 16'h0000) begin
               next_flag = 1'b1;
            end
         end else if (!cur_prev) begin
            next_pv = sv_eff;
            next_flag = (sv_eff == 16'h0000);
            next_prev = 1'b1;
            tick_clear[slot] = 1'b1;
         end else if (cur_pv == 16'h0000) begin
            next_flag = 1'b1;
         end else if (tick_pend[slot]) begin
            next_pv = bcd_dec(cur_pv);
            next_flag = (bcd_dec(cur_pv) == 16'h0000);
            tick_clear[slot] = 1'b1;
         end
      end
   end

   assign done_event = exec_go && next_flag && !cur_flag;

   // timer storage, power interruption clears every slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `ODTB_SLOT_COUNT; i++) begin
            present_value[i] <= `ODTB_WORD_RESET;
         end
         done_flag <= '0;
         cond_prev <= '0;
      end else if (all_reset) begin
         for (int i = 0; i < `ODTB_SLOT_COUNT; i++) begin
            present_value[i] <= `ODTB_WORD_RESET;
         end
         done_flag <= '0;
         cond_prev <= '0;
      end else if (exec_go) begin
         present_value[slot] <= next_pv;
         done_flag[slot] <= next_flag;
         cond_prev[slot] <= next_prev;
      end
   end

   // error flag follows the latest execute
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instruction_error_flag <= 1'b0;
      end else if (wr_exec) begin
         instruction_error_flag <= exec_err;
      end
   end

   // ==========================================================
   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot <= `ODTB_SLOT_RESET;
         set_value <= `ODTB_WORD_RESET;
         pointer <= `ODTB_WORD_RESET;
         mode <= ODTB_MODE_PROGRAM;
         irq_enable <= `ODTB_IRQ_RESET;
      end else begin
         if (is_write(paddr, `ODTB_OFS_SLOT, psel, penable, pwrite, pready)) begin
            slot <= pwdata[8:0];
         end
         if (is_write(paddr, `ODTB_OFS_SETVAL, psel, penable, pwrite, pready)) begin
            set_value <= pwdata[15:0];
         end
         if (is_write(paddr, `ODTB_OFS_POINTER, psel, penable, pwrite, pready)) begin
            pointer <= pwdata[15:0];
         end
         if (wr_mode) begin
            mode <= odtb_mode_t'(pwdata[1:0]);
         end
         if (is_write(paddr, `ODTB_OFS_IRQ_ENABLE, psel, penable, pwrite, pready)) begin
            irq_enable <= pwdata[2:0];
         end
      end
   end

   // sticky events, a new event wins over a clear in the same cycle
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   assign irq_set = {exec_refused, exec_err, done_event};
   assign irq_clr = is_write(paddr, `ODTB_OFS_IRQ_CLEAR, psel, penable, pwrite, pready) ?
      pwdata[2:0] : 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `ODTB_IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= irq_set | (irq_status & ~irq_clr);
         irq <= |((irq_set | (irq_status & ~irq_clr)) & irq_enable);
      end
   end

   // ==========================================================
   // apb answer: ready in the first access cycle, read data latched at setup
   logic [31:0] rd_word;
   logic rd_known;

   always_comb begin
      rd_word = 32'h0;
      rd_known = 1'b1;
      case (paddr)
         `ODTB_OFS_SLOT: rd_word = {23'h0, slot};
         `ODTB_OFS_SETVAL: rd_word = {16'h0, set_value};
         `ODTB_OFS_POINTER: rd_word = {16'h0, pointer};
         `ODTB_OFS_EXEC: rd_word = 32'h0;
         `ODTB_OFS_MODE: rd_word = {30'h0, mode};
         `ODTB_OFS_FLAG: rd_word = {30'h0, clock_pulse_1s, cur_flag};
         `ODTB_OFS_PV: rd_word = {16'h0, cur_pv};
         `ODTB_OFS_ERROR: rd_word = {31'h0, instruction_error_flag};
         `ODTB_OFS_IRQ_STATUS: rd_word = {29'h0, irq_status};
         `ODTB_OFS_IRQ_CLEAR: rd_word = 32'h0;
         `ODTB_OFS_IRQ_ENABLE: rd_word = {29'h0, irq_enable};
         default: rd_known = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0 : rd_word;
         pready <= 1'b1;
         pslverr <= !rd_known;
      end else if (access) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule // odtb_timer_bank

// *** testbench/odtb_timer_bank_sva.sv ***
/*
 concurrent checks on the apb slave and pulse output of the on-delay timer bank.
 assumes it is bound to odtb_timer_bank and sees its ports only.
*/
`timescale 1ns/100ps
module odtb_timer_bank_sva #(
   parameter int TICK_CYCLES = 20,
   parameter int HALF_PULSE_CYCLES = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // input-unit word and status
   input wire logic [15:0] ext_set_value,
   input wire logic clock_pulse_1s,
   input wire logic instruction_error_flag,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic prev_pulse;
   logic seen;
   int cnt;
   wire setup = psel && !penable;
   // ==========================================================
   // cycles since the pulse bit last changed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_pulse <= 1'b0;
         seen <= 1'b0;
         cnt <= 0;
      end else begin
         prev_pulse <= clock_pulse_1s;
         if (clock_pulse_1s != prev_pulse) begin
            seen <= 1'b1;
            cnt <= 0;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
   // ==========================================================
   // assertions
   ready_after_setup_a: assert property (setup |=> pready)
      else $error("pready missing after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_unmapped_a: assert property (setup && paddr > 12'h028 |=> pready && pslverr)
      else $error("unmapped access not refused");
   err_mapped_a: assert property (setup && paddr <= 12'h028 && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
   exec_reads_zero_a: assert property (setup && !pwrite && paddr == 12'h00c |=> prdata == 32'h0)
      else $error("exec register read not zero");
   rdata_hold_a: assert property (pready |=> $stable(prdata))
      else $error("read data not held");
   flag_pulse_bit_a: assert property (
      setup && !pwrite && paddr == 12'h014 |=> prdata[1] == $past(clock_pulse_1s))
      else $error("pulse bit read wrong");
   pulse_period_a: assert property (seen && clock_pulse_1s != prev_pulse |->
      cnt == HALF_PULSE_CYCLES - 1)
      else $error("pulse half period wrong");
   pulse_hold_a: assert property (seen |-> cnt < HALF_PULSE_CYCLES)
      else $error("pulse held too long");
   irq_masked_a: assert property (psel && penable && pready && pwrite && paddr == 12'h028
      && pwdata[2:0] == 3'h0 |=> ##1 !irq)
      else $error("irq high with all sources masked");
   err_only_on_exec_a: assert property (
      !(psel && penable && pready && pwrite && paddr == 12'h00c)
      |=> $stable(instruction_error_flag))
      else $error("error flag changed without an execute write");
   cover property (setup && pwrite && paddr == 12'h00c);
   cover property ($rose(instruction_error_flag));
   cover property (pslverr);
   cover property (irq);
endmodule // odtb_timer_bank_sva

// *** testbench/test_odtb_timer_bank.sv ***
/*
 self-checking bench of the on-delay timer bank, driven over apb.
 assumes the package, defines header and checker are compiled first.
*/
`timescale 1ns/100ps
`include "odtb_defs.svh"
module test_odtb_timer_bank;
   import odtb_pkg::*;
   localparam int TICK = 20;
   localparam int HALF = 16;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, se, p;
   logic clock_pulse_1s, instruction_error_flag, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] ext_set_value;
   int err_total = 0;
   int comparisons = 0;
   int n;
   always #10 pclk = ~pclk;
   odtb_timer_bank #(.TICK_CYCLES(TICK), .HALF_PULSE_CYCLES(HALF)) odtb_timer_bank_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_set_value(ext_set_value), .clock_pulse_1s(clock_pulse_1s),
      .instruction_error_flag(instruction_error_flag), .irq(irq));
   // ==========================================================
   // access tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until pready is sampled high at a rising edge, the watchdog ends a hang
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   task automatic step(input logic [6:0] c, input logic [15:0] pv, input logic fl);
      wr(`ODTB_OFS_EXEC, {25'h0, c});
      rdc(`ODTB_OFS_PV, {16'h0, pv});
      xfer(1'b0, `ODTB_OFS_FLAG, 32'h0);
      check({31'h0, rd[0]}, {31'h0, fl});
   endtask
   task automatic tick;
      repeat (TICK + 5) @(posedge pclk);
   endtask
   task automatic results;
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      results;
   end
   // ==========================================================
   // tests
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      ext_set_value = 16'h0042;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(`ODTB_OFS_PV, 32'h0);
      rdc(`ODTB_OFS_MODE, 32'h0);
      rdc(`ODTB_OFS_EXEC, 32'h0);
      xfer(1'b0, 12'h030, 32'h0);
      check({31'h0, se}, 32'h1);
      check(rd, 32'h0);
      wr(`ODTB_OFS_SLOT, 32'h14);
      wr(`ODTB_OFS_SETVAL, 32'h2);
      step(7'h00, 16'h0002, 1'b0);
      step(7'h01, 16'h0002, 1'b0);
      tick;
      step(7'h01, 16'h0001, 1'b0);
      tick;
      step(7'h01, 16'h0000, 1'b1);
      tick;
      step(7'h01, 16'h0000, 1'b1);
      step(7'h00, 16'h0002, 1'b0);
      wr(`ODTB_OFS_SETVAL, 32'h100);
      step(7'h01, 16'h0100, 1'b0);
      tick;
      step(7'h01, 16'h0099, 1'b0);
      wr(`ODTB_OFS_SETVAL, 32'h0);
      step(7'h00, 16'h0000, 1'b0);
      step(7'h01, 16'h0000, 1'b1);
      step(7'h00, 16'h0000, 1'b0);
      step(7'h11, 16'h0000, 1'b0);
      step(7'h31, 16'h0000, 1'b1);
      step(7'h00, 16'h0000, 1'b0);
      step(7'h40, 16'h0000, 1'b1);
      step(7'h01, 16'h0000, 1'b1);
      step(7'h09, 16'h0000, 1'b0);
      wr(`ODTB_OFS_SETVAL, 32'h3);
      step(7'h00, 16'h0003, 1'b0);
      wr(`ODTB_OFS_MODE, 32'h100);
      rdc(`ODTB_OFS_PV, 32'h0);
      wr(`ODTB_OFS_SLOT, 32'h1ff);
      step(7'h00, 16'h0003, 1'b0);
      wr(`ODTB_OFS_SLOT, 32'h14);
      rdc(`ODTB_OFS_PV, 32'h0);
      wr(`ODTB_OFS_SETVAL, 32'ha5);
      wr(`ODTB_OFS_EXEC, 32'h0);
      check({31'h0, instruction_error_flag}, 32'h1);
      rdc(`ODTB_OFS_PV, 32'ha5);
      wr(`ODTB_OFS_SETVAL, 32'h7);
      wr(`ODTB_OFS_POINTER, 32'h2000);
      wr(`ODTB_OFS_EXEC, 32'h2);
      rdc(`ODTB_OFS_ERROR, 32'h1);
      wr(`ODTB_OFS_POINTER, 32'hf0);
      step(7'h02, 16'h00a5, 1'b0);
      rdc(`ODTB_OFS_ERROR, 32'h1);
      wr(`ODTB_OFS_POINTER, 32'h1999);
      step(7'h02, 16'h0007, 1'b0);
      rdc(`ODTB_OFS_ERROR, 32'h0);
      step(7'h04, 16'h0007, 1'b0);
      rdc(`ODTB_OFS_IRQ_STATUS, 32'h7);
      wr(`ODTB_OFS_MODE, 32'h2);
      step(7'h04, 16'h0042, 1'b0);
      ext_set_value <= 16'h0013;
      wr(`ODTB_OFS_MODE, 32'h1);
      step(7'h04, 16'h0013, 1'b0);
      wr(`ODTB_OFS_IRQ_ENABLE, 32'h7);
      rdc(`ODTB_OFS_IRQ_ENABLE, 32'h7);
      check({31'h0, irq}, 32'h1);
      wr(`ODTB_OFS_IRQ_CLEAR, 32'h7);
      wr(`ODTB_OFS_IRQ_ENABLE, 32'h1);
      rdc(`ODTB_OFS_IRQ_STATUS, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(`ODTB_OFS_SETVAL, 32'hb0);
      wr(`ODTB_OFS_EXEC, 32'h0);
      rdc(`ODTB_OFS_IRQ_STATUS, 32'h2);
      check({31'h0, irq}, 32'h0);
      wr(`ODTB_OFS_IRQ_ENABLE, 32'h2);
      rdc(`ODTB_OFS_IRQ_STATUS, 32'h2);
      check({31'h0, irq}, 32'h1);
      wr(`ODTB_OFS_IRQ_ENABLE, 32'h0);
      @(negedge pclk);
      p = clock_pulse_1s;
      n = 0;
      while (clock_pulse_1s === p && n < 100) begin
         @(negedge pclk);
         n++;
      end
      p = clock_pulse_1s;
      n = 0;
      while (clock_pulse_1s === p && n < 100) begin
         @(negedge pclk);
         n++;
      end
      check(32'(n), 32'(HALF));
      results;
   end
endmodule // test_odtb_timer_bank
bind odtb_timer_bank odtb_timer_bank_sva #(
   .TICK_CYCLES(TICK_CYCLES), .HALF_PULSE_CYCLES(HALF_PULSE_CYCLES)
) odtb_timer_bank_sva_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_set_value(ext_set_value), .clock_pulse_1s(clock_pulse_1s),
   .instruction_error_flag(instruction_error_flag), .irq(irq));
